// *** inc/scm_pkg.sv ***
// constants for the crossing / off-track command register block
package scm_pkg;
	// ****************************************
	// bus map (byte address = 4 x index)
	// ****************************************
	localparam logic [7:0] SCM_IDX_XCFG = 8'h3c;
	localparam logic [7:0] SCM_IDX_SCFG = 8'h3d;
	localparam logic [7:0] SCM_IDX_STAT = 8'h40;
	localparam logic [15:0] SCM_XCFG_RST = 16'h0080;
	localparam logic [15:0] SCM_SCFG_RST = 16'h0000;
	localparam logic [15:0] SCM_XCFG_WMASK = 16'hfef0;
	localparam logic [15:0] SCM_SCFG_WMASK = 16'hf700;
	// field positions of the crossing register
	localparam int SCM_B_ZC_SAMPLED = 15;
	localparam int SCM_B_ZC_DELAYED = 14;
	localparam int SCM_B_ZC_CENTER = 13;
	localparam int SCM_B_TF_CENTER = 12;
	localparam int SCM_B_CP_HI = 11;
	localparam int SCM_B_CP_LO = 10;
	localparam int SCM_B_MIR_REDIR = 9;
	localparam int SCM_B_BR_HI = 7;
	localparam int SCM_B_BR_LO = 6;
	localparam int SCM_B_QT_HI = 5;
	localparam int SCM_B_QT_LO = 4;
	// field positions of the sled / hold register
	localparam int SCM_B_SLED_SRC = 15;
	localparam int SCM_B_SLED_SWAP = 14;
	localparam int SCM_B_HOLD_SRC = 13;
	localparam int SCM_B_HOLD_SWAP = 12;
	localparam int SCM_B_CORR_OFF = 8;
	// ****************************************
	// timing at a 5 ns clock
	// ****************************************
	localparam int SCM_CLK_PS = 5000;
	localparam int SCM_SAMPLE_KHZ = 700;
	localparam int SCM_STEP_NS = 708;
	localparam int SCM_QT0_NS1000 = 5669;
	localparam int SCM_QT1_NS1000 = 11338;
	localparam int SCM_QT2_NS1000 = 22675;
	localparam int SCM_QT3_NS1000 = 45351;
	localparam int SCM_HPF_SHIFT = 7; // 1 kHz corner at 700 kHz rate
	localparam int SCM_DOUBLE_STEPS = 8;
	// least time in ps rounded up to whole clocks
	function automatic int scm_cyc_up(input int t_ps);
		return (t_ps + SCM_CLK_PS - 1) / SCM_CLK_PS;
	endfunction
	localparam int SCM_SAMPLE_CYC = 1000000000 / (SCM_SAMPLE_KHZ * SCM_CLK_PS);
	localparam int SCM_STEP_CYC = scm_cyc_up(SCM_STEP_NS * 1000);
	// qualification limits in whole clocks; the times above are in ns
	localparam int SCM_QT0_CYC = scm_cyc_up(SCM_QT0_NS1000 * 1000);
	localparam int SCM_QT1_CYC = scm_cyc_up(SCM_QT1_NS1000 * 1000);
	localparam int SCM_QT2_CYC = scm_cyc_up(SCM_QT2_NS1000 * 1000);
	localparam int SCM_QT3_CYC = scm_cyc_up(SCM_QT3_NS1000 * 1000);
endpackage

// *** logic/scm_crossing_mirror.sv ***
// crossing select, off-track detector and sled/hold routing behind ahb-lite
`timescale 1ns/1ps
// How it works
// - count source: upper bit picks sampled, else 00 high-pass, 01 delayed; reset high-pass
// - sampled zero-cross is the error sign taken at the 700 kHz rate
// - delayed zero-cross lags sampled by one or two samples, picked externally
// - high-pass zero-cross is error sign after a 1 kHz high-pass
// - zero-cross taken from tracking error, or center error when bit set
// - tracking filter fed from tracking error, or center error when bit set
// - crossing pin: upper bit sampled, 01 high-pass, 00 normal count (reset)
// - redirect bit puts sampled zero-cross on the off-track pin
// - bottom hold rises 1/2/4/8 steps each ~708 ns; reset code 10
// - rate code used only while double-speed mode is off
// - off-track flag only after excess held for the whole qualification time
// - qualification time 5.669/11.338/22.675/45.351 us; reset 00
// - sled input from stage-two result when bit set, else sled register
// - sled coefficient swapped only with swap bit and gain-up2
// - hold input from stage-two result when bit set, else sled register
// - hold coefficient swapped only with swap bit and gain-up2
// - main bit off: no correction; sled-off bit limits it to tracking
// - sled-off bits: traverse, zero level, reference level, high to low
// - double-speed mode makes the bottom hold rise 8 steps each time, whatever the rate code
module scm_crossing_mirror
	import scm_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic signed [7:0] track_err_in_i,
	input wire logic signed [7:0] center_err_in_i,
	input wire logic zc_delay_long_i,
	input wire logic bottom_double_speed_i,
	input wire logic [7:0] rf_env_i,
	input wire logic [7:0] mirror_level_i,
	input wire logic [7:0] sled_reg_i,
	input wire logic [7:0] track_stage2_result_i,
	input wire logic [7:0] sled_input_coef_i,
	input wire logic [7:0] gainup_sled_coef_i,
	input wire logic [7:0] hold_input_coef_i,
	input wire logic [7:0] gainup_hold_coef_i,
	input wire logic gainup2_i,
	input wire logic [2:0] corr_on_i,
	output logic signed [7:0] trkfilt_in_o,
	output logic [7:0] sled_filt_in_o,
	output logic [7:0] sled_coef_o,
	output logic [7:0] hold_filt_in_o,
	output logic [7:0] hold_coef_o,
	output logic [2:0] trk_corr_en_o,
	output logic [2:0] sled_corr_en_o,
	output logic track_crossing_count_o,
	output logic off_track_flag_o
);
	// ****************************************
	// bus slave
	// ****************************************
	logic [15:0] xcfg_q;
	logic [15:0] scfg_q;
	logic wr_pend_q;
	logic [7:0] wr_idx_q;
	logic [7:0] a_idx;
	logic a_take;
	logic [4:0] stat;
	assign a_idx = haddr_i[9:2];
	assign a_take = hsel_i && htrans_i[1] && hready_i;

	// zero wait state, always okay
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// address phase capture of writes
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= a_take && hwrite_i;
			wr_idx_q <= a_idx;
		end
	end

	// command registers; fixed-zero positions never store
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			xcfg_q <= SCM_XCFG_RST;
			scfg_q <= SCM_SCFG_RST;
		end
		else if (wr_pend_q)
		begin
			if (wr_idx_q == SCM_IDX_XCFG)
				xcfg_q <= hwdata_i[15:0] & SCM_XCFG_WMASK;
			if (wr_idx_q == SCM_IDX_SCFG)
				scfg_q <= hwdata_i[15:0] & SCM_SCFG_WMASK;
		end
	end

	// read data prepared in the address phase; command registers are write-only
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			hrdata_o <= 32'h0000_0000;
		else if (a_take && !hwrite_i && a_idx == SCM_IDX_STAT)
			hrdata_o <= {27'h000_0000, stat};
		else if (a_take)
			hrdata_o <= 32'h0000_0000;
	end

	// ****************************************
	// zero-cross generation
	// ****************************************
	logic [8:0] samp_cnt_q;
	logic samp_tick;
	logic signed [7:0] zc_src;
	logic sampled_q;
	logic [1:0] dly_q;
	logic delayed;
	logic signed [15:0] hp_avg_q;
	logic signed [15:0] hp_diff;
	logic highpass_q;
	logic track_zero_cross;
	assign samp_tick = samp_cnt_q == 9'(SCM_SAMPLE_CYC - 1);
	assign zc_src = xcfg_q[SCM_B_ZC_CENTER] ? center_err_in_i : track_err_in_i;
	assign hp_diff = 16'({zc_src, 8'h00}) - hp_avg_q;
	assign delayed = zc_delay_long_i ? dly_q[1] : dly_q[0];

	// 700 kHz sample enable
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			samp_cnt_q <= 9'h000;
		else if (samp_tick)
			samp_cnt_q <= 9'h000;
		else
			samp_cnt_q <= samp_cnt_q + 9'h001;
	end

	// sampled sign, its delay line and the high-pass sign
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sampled_q <= 1'b0;
			dly_q <= 2'b00;
			hp_avg_q <= 16'sh0000;
			highpass_q <= 1'b0;
		end
		else if (samp_tick)
		begin
			sampled_q <= !zc_src[7];
			dly_q <= {dly_q[0], sampled_q};
			hp_avg_q <= hp_avg_q + (hp_diff >>> SCM_HPF_SHIFT);
			highpass_q <= !hp_diff[15];
		end
	end

	// count source select
	always_comb
	begin
		if (xcfg_q[SCM_B_ZC_SAMPLED])
			track_zero_cross = sampled_q;
		else if (xcfg_q[SCM_B_ZC_DELAYED])
			track_zero_cross = delayed;
		else
			track_zero_cross = highpass_q;
	end

	// normal crossing count toggles on each rising crossing
	logic tzc_last_q;
	logic count_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tzc_last_q <= 1'b0;
			count_q <= 1'b0;
		end
		else
		begin
			tzc_last_q <= track_zero_cross;
			if (track_zero_cross && !tzc_last_q)
				count_q <= !count_q;
		end
	end

	// ****************************************
	// off-track detector
	// ****************************************
	logic [7:0] step_cnt_q;
	logic step_tick;
	logic [7:0] bottom_q;
	logic [7:0] peak_q;
	logic [8:0] bottom_up;
	logic [3:0] rise;
	logic [7:0] excess;
	logic [13:0] qual_cnt_q;
	logic [13:0] qual_lim;
	logic mirror_q;
	assign step_tick = step_cnt_q == 8'(SCM_STEP_CYC - 1);
	assign excess = peak_q - bottom_q;

	// steps per cycle from the rate code unless double speed is on
	always_comb
	begin
		if (bottom_double_speed_i)
			rise = 4'(SCM_DOUBLE_STEPS);
		else
			rise = 4'h1 << {xcfg_q[SCM_B_BR_HI], xcfg_q[SCM_B_BR_LO]};
		bottom_up = {1'b0, bottom_q} + {5'h00, rise};
	end

	// qualification time per code
	always_comb
	begin
		unique case ({xcfg_q[SCM_B_QT_HI], xcfg_q[SCM_B_QT_LO]})
			2'b00: qual_lim = 14'(SCM_QT0_CYC);
			2'b01: qual_lim = 14'(SCM_QT1_CYC);
			2'b10: qual_lim = 14'(SCM_QT2_CYC);
			2'b11: qual_lim = 14'(SCM_QT3_CYC);
		endcase
	end

	// hold step enable, about 708 ns
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			step_cnt_q <= 8'h00;
		else if (step_tick)
			step_cnt_q <= 8'h00;
		else
			step_cnt_q <= step_cnt_q + 8'h01;
	end

	// bottom follows down at once and creeps up; peak the mirror image
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bottom_q <= 8'h00;
			peak_q <= 8'h00;
		end
		else
		begin
			if (rf_env_i < bottom_q)
				bottom_q <= rf_env_i;
			else if (step_tick)
				bottom_q <= (bottom_up > {1'b0, rf_env_i}) ? rf_env_i : bottom_up[7:0];
			if (rf_env_i > peak_q)
				peak_q <= rf_env_i;
			else if (step_tick && peak_q != 8'h00)
				peak_q <= peak_q - 8'h01;
		end
	end

	// flag only after a continuous run above the comparator level
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			qual_cnt_q <= 14'h0000;
			mirror_q <= 1'b0;
		end
		else if (excess > mirror_level_i)
		begin
			if (qual_cnt_q < qual_lim)
				qual_cnt_q <= qual_cnt_q + 14'h0001;
			mirror_q <= qual_cnt_q >= qual_lim;
		end
		else
		begin
			qual_cnt_q <= 14'h0000;
			mirror_q <= 1'b0;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	logic [1:0] cp_sel;
	assign cp_sel = {xcfg_q[SCM_B_CP_HI], xcfg_q[SCM_B_CP_LO]};
	assign stat = {mirror_q, count_q, delayed, highpass_q, sampled_q};

	// pins and filter routing
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			track_crossing_count_o <= 1'b0;
			off_track_flag_o <= 1'b0;
			trkfilt_in_o <= 8'sh00;
			sled_filt_in_o <= 8'h00;
			sled_coef_o <= 8'h00;
			hold_filt_in_o <= 8'h00;
			hold_coef_o <= 8'h00;
			trk_corr_en_o <= 3'b000;
			sled_corr_en_o <= 3'b000;
		end
		else
		begin
			if (cp_sel[1])
				track_crossing_count_o <= sampled_q;
			else if (cp_sel[0])
				track_crossing_count_o <= highpass_q;
			else
				track_crossing_count_o <= count_q;
			off_track_flag_o <= xcfg_q[SCM_B_MIR_REDIR] ? sampled_q : mirror_q;
			trkfilt_in_o <= xcfg_q[SCM_B_TF_CENTER] ? center_err_in_i : track_err_in_i;
			sled_filt_in_o <= scfg_q[SCM_B_SLED_SRC] ? track_stage2_result_i : sled_reg_i;
			sled_coef_o <= (scfg_q[SCM_B_SLED_SWAP] && gainup2_i)
				? gainup_sled_coef_i : sled_input_coef_i;
			hold_filt_in_o <= scfg_q[SCM_B_HOLD_SRC] ? track_stage2_result_i : sled_reg_i;
			hold_coef_o <= (scfg_q[SCM_B_HOLD_SWAP] && gainup2_i)
				? gainup_hold_coef_i : hold_input_coef_i;
			trk_corr_en_o <= corr_on_i;
			// bit 2 traverse, 1 zero level, 0 reference level
			sled_corr_en_o <= corr_on_i & ~scfg_q[SCM_B_CORR_OFF +: 3];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_redir_pin: assert property (xcfg_q[SCM_B_MIR_REDIR] |=> off_track_flag_o == $past(sampled_q))
		else $error("off-track pin not redirected");
	chk_cross_pin: assert property (cp_sel == 2'b00 |=> track_crossing_count_o == $past(count_q))
		else $error("crossing pin not normal count");
	chk_zc_source: assert property (samp_tick && xcfg_q[SCM_B_ZC_CENTER] |=> sampled_q == !$past(center_err_in_i[7]))
		else $error("zero-cross source wrong");
	chk_sample_rate: assert property (samp_tick |=> !samp_tick [*8])
		else $error("sample tick too frequent");
	chk_mirror_qual: assert property ($rose(mirror_q) |-> $past(qual_cnt_q) >= $past(qual_lim)
		&& $past(excess) > $past(mirror_level_i))
		else $error("off-track flag before qualification");
	chk_mirror_drop: assert property (excess <= mirror_level_i |=> !mirror_q)
		else $error("off-track flag held without excess");
	chk_qual_reset: assert property ($rose(rst_n_i) |-> qual_lim == 14'(SCM_QT0_CYC))
		else $error("qualification preset wrong");
	chk_bottom_rise: assert property (step_tick && !bottom_double_speed_i && bottom_q < 8'hf0
		&& rf_env_i >= bottom_q + 8'(SCM_DOUBLE_STEPS) |=> bottom_q == $past(bottom_q)
		+ (8'h01 << {$past(xcfg_q[SCM_B_BR_HI]), $past(xcfg_q[SCM_B_BR_LO])}))
		else $error("bottom hold rise wrong");
	chk_double_rise: assert property (bottom_double_speed_i |-> rise == 4'(SCM_DOUBLE_STEPS))
		else $error("double speed ignored");
	chk_sled_swap: assert property (!gainup2_i |=> sled_coef_o == $past(sled_input_coef_i))
		else $error("sled coefficient swapped outside gain-up2");
	chk_hold_swap: assert property (!gainup2_i |=> hold_coef_o == $past(hold_input_coef_i))
		else $error("hold coefficient swapped outside gain-up2");
	chk_corr_off: assert property (!corr_on_i[0] |=> !sled_corr_en_o[0] && !trk_corr_en_o[0])
		else $error("correction on without main bit");
	chk_src_sel: assert property (xcfg_q[SCM_B_ZC_SAMPLED] |-> track_zero_cross == sampled_q)
		else $error("count source wrong");

	cov_mirror: cover property ($rose(off_track_flag_o));
	cov_redir: cover property (xcfg_q[SCM_B_MIR_REDIR] && sampled_q);
	cov_swap: cover property (scfg_q[SCM_B_SLED_SWAP] && gainup2_i);
endmodule // scm_crossing_mirror

// *** sim/servo_crossing_mirror_config_test.sv ***
// self-checking bench for the crossing / off-track command register block
`timescale 1ns/1ps
module servo_crossing_mirror_config_test
	import scm_pkg::*;
;
	// ****************************************
	// stimulus signals and tables
	// ****************************************
	typedef struct {logic [15:0] x, s; logic g; logic [2:0] c; logic [7:0] tracking_servo, sin, sc, hin, hc; logic [2:0] te_en, se_en;} scm_row_t;
	typedef struct {logic [15:0] x; logic [7:0] te, ce; logic dl, zc;} scm_zc_t;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, track_crossing_count_o, off_track_flag_o;
	logic [7:0] te = 8'h05, ce = 8'hfb, rf_env = 8'h00;
	logic gainup2 = 1'b0, toggle_on = 1'b0;
	logic zc_long = 1'b0, dbl_speed = 1'b0;
	logic [7:0] level = 8'h20, sled_reg = 8'h11;
	logic [2:0] corr_on = 3'h0;
	logic signed [7:0] trkfilt_in_o;
	logic [7:0] sled_filt_in_o, sled_coef_o, hold_filt_in_o, hold_coef_o;
	logic [2:0] trk_corr_en_o, sled_corr_en_o;
	logic [31:0] rd;
	int n_mismatch = 0;
	int checks = 0;
	// plain rows: crossing cfg, sled cfg, gain-up2, main corr, expected routing
	scm_row_t rows [7] = '{
		'{16'h0000, 16'h0000, 1'b0, 3'h7, 8'h05, 8'h11, 8'h33, 8'h11, 8'h55, 3'h7, 3'h7},
		'{16'h1000, 16'hf700, 1'b0, 3'h7, 8'hfb, 8'h22, 8'h33, 8'h22, 8'h55, 3'h7, 3'h0},
		'{16'h1000, 16'hf700, 1'b1, 3'h5, 8'hfb, 8'h22, 8'h44, 8'h22, 8'h66, 3'h5, 3'h0},
		'{16'h0000, 16'h5200, 1'b1, 3'h3, 8'h05, 8'h11, 8'h44, 8'h11, 8'h66, 3'h3, 3'h1},
		'{16'h0000, 16'h0400, 1'b1, 3'h4, 8'h05, 8'h11, 8'h33, 8'h11, 8'h55, 3'h4, 3'h0},
		'{16'h0000, 16'h0100, 1'b0, 3'h1, 8'h05, 8'h11, 8'h33, 8'h11, 8'h55, 3'h1, 3'h0},
		'{16'h0000, 16'h0000, 1'b0, 3'h0, 8'h05, 8'h11, 8'h33, 8'h11, 8'h55, 3'h0, 3'h0}};
	// zero-cross rows; sign is 1 for a non-negative error
	// each row steps the source the same way as its sign, so the high-pass sign agrees
	scm_zc_t zrows [4] = '{
		'{16'h4a00, 8'hfb, 8'h05, 1'b0, 1'b0},
		'{16'h0a00, 8'h00, 8'hfb, 1'b1, 1'b1},
		'{16'h2600, 8'h05, 8'hfb, 1'b0, 1'b0},
		'{16'h6600, 8'hfb, 8'h05, 1'b1, 1'b1}};
	// ****************************************
	// clock, envelope toggler and design
	// ****************************************
	initial
	begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// square envelope keeps bottom at zero and peak high, so excess stays above level
	always @(posedge sys_clk_i)
	begin
		rf_env <= toggle_on ? ((rf_env == 8'h00) ? 8'hfa : 8'h00) : 8'h00;
	end
	scm_crossing_mirror u_scm_crossing_mirror (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .track_err_in_i(te), .center_err_in_i(ce),
		.zc_delay_long_i(zc_long), .bottom_double_speed_i(dbl_speed), .rf_env_i(rf_env),
		.mirror_level_i(level), .sled_reg_i(sled_reg), .track_stage2_result_i(8'h22),
		.sled_input_coef_i(8'h33), .gainup_sled_coef_i(8'h44), .hold_input_coef_i(8'h55),
		.gainup_hold_coef_i(8'h66), .gainup2_i(gainup2), .corr_on_i(corr_on),
		.trkfilt_in_o(trkfilt_in_o), .sled_filt_in_o(sled_filt_in_o),
		.sled_coef_o(sled_coef_o), .hold_filt_in_o(hold_filt_in_o), .hold_coef_o(hold_coef_o),
		.trk_corr_en_o(trk_corr_en_o), .sled_corr_en_o(sled_corr_en_o),
		.track_crossing_count_o(track_crossing_count_o), .off_track_flag_o(off_track_flag_o));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for hready; a hang is counted instead of waited out
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (hreadyout_o !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			check(32'h0, 32'h1);
			give_verdict();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		hsel_i <= 1'b1;
		haddr_i <= {22'h0, idx, 2'b00};
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		hsize_i <= 3'h2;
		wait_ready();
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		wait_ready();
		rd = hrdata_o;
		check({31'h0, hresp_o}, 32'h0);
	endtask
	task automatic do_reset();
		rst_n_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
	endtask
	// flag must stay low up to lo cycles of excess and be up by hi cycles
	task automatic mirror_run(input int lo, input int hi);
		toggle_on <= 1'b1;
		repeat (lo) @(posedge sys_clk_i);
		check({31'h0, off_track_flag_o}, 32'h0);
		repeat (hi - lo) @(posedge sys_clk_i);
		check({31'h0, off_track_flag_o}, 32'h1);
		toggle_on <= 1'b0;
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		// outputs while reset is held, six cycles in all
		repeat (3) @(posedge sys_clk_i);
		check({31'h0, hreadyout_o}, 32'h1);
		check({29'h0, trk_corr_en_o}, 32'h0);
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		// routing table; rows keep fixed-zero positions clear
		foreach (rows[i])
		begin
			bus(1'b1, SCM_IDX_XCFG, {16'h0, rows[i].x});
			bus(1'b1, SCM_IDX_SCFG, {16'h0, rows[i].s});
			gainup2 <= rows[i].g;
			corr_on <= rows[i].c;
			repeat (4) @(posedge sys_clk_i);
			check({24'h0, trkfilt_in_o}, {24'h0, rows[i].tracking_servo});
			check({24'h0, sled_filt_in_o}, {24'h0, rows[i].sin});
			check({24'h0, sled_coef_o}, {24'h0, rows[i].sc});
			check({24'h0, hold_filt_in_o}, {24'h0, rows[i].hin});
			check({24'h0, hold_coef_o}, {24'h0, rows[i].hc});
			check({29'h0, trk_corr_en_o}, {29'h0, rows[i].te_en});
			check({29'h0, sled_corr_en_o}, {29'h0, rows[i].se_en});
		end
		// zero-cross signs on both pins and in status; 900 cycles cover three samples
		foreach (zrows[i])
		begin
			bus(1'b1, SCM_IDX_XCFG, {16'h0, zrows[i].x});
			te <= zrows[i].te;
			ce <= zrows[i].ce;
			zc_long <= zrows[i].dl;
			repeat (900) @(posedge sys_clk_i);
			check({31'h0, track_crossing_count_o}, {31'h0, zrows[i].zc});
			check({31'h0, off_track_flag_o}, {31'h0, zrows[i].zc});
			bus(1'b0, SCM_IDX_STAT, 32'h0);
			check({31'h0, rd[0]}, {31'h0, zrows[i].zc});
			check({31'h0, rd[1]}, {31'h0, zrows[i].zc});
			check({31'h0, rd[2]}, {31'h0, zrows[i].zc});
		end
		// registers are write-only, unmapped space reads zero
		bus(1'b0, SCM_IDX_XCFG, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 8'h80, 32'h0);
		check(rd, 32'h0);
		// preset source is high-pass; normal count toggles on each rising crossing
		do_reset();
		te <= 8'h05;
		repeat (300) @(posedge sys_clk_i);
		check({31'h0, track_crossing_count_o}, 32'h1);
		te <= 8'hfb;
		repeat (300) @(posedge sys_clk_i);
		te <= 8'h05;
		repeat (300) @(posedge sys_clk_i);
		check({31'h0, track_crossing_count_o}, 32'h0);
		// preset qualification code 00 and rate code 10
		mirror_run(1100, 1200);
		do_reset();
		bus(1'b1, SCM_IDX_XCFG, 32'h0000_0090);
		mirror_run(2230, 2330);
		// double speed with the longest qualification time
		do_reset();
		dbl_speed <= 1'b1;
		bus(1'b1, SCM_IDX_XCFG, 32'h0000_00f0);
		mirror_run(9000, 9120);
		give_verdict();
	end
	// watchdog well beyond the roughly 17500 cycles of the sequence
	initial
	begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
endmodule // servo_crossing_mirror_config_test
